// File: src/gpi_tally_port_logic.sv
`timescale 1ns/1ns
module gpi_tally_port_logic #(
  parameter int NUM_PORTS = gpi_tally_pkg::NUM_PORTS_DEF,
  parameter int FILTER_CYCLES = gpi_tally_pkg::FILTER_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic frame_strobe,
  input wire logic pin_in [NUM_PORTS],
  input wire gpi_tally_pkg::func_t func_sel [NUM_PORTS],
  input wire logic trig_level [NUM_PORTS],
  input wire logic polarity [NUM_PORTS],
  input wire logic [gpi_tally_pkg::PW_W-1:0] pulse_frames [NUM_PORTS],
  input wire logic ovr_en [NUM_PORTS],
  input wire logic ovr_level [NUM_PORTS],
  input wire logic remote_trig [NUM_PORTS],
  input wire logic cmd_valid [NUM_PORTS],
  input wire logic cmd_level [NUM_PORTS],
  input wire logic [gpi_tally_pkg::ON_AIR_INPUTS-1:0] on_air,
  input wire logic [gpi_tally_pkg::ON_AIR_INPUTS-1:0]
    tally_sel [NUM_PORTS],
  output logic pin_out [NUM_PORTS],
  output logic pin_oe [NUM_PORTS],
  output logic fire [NUM_PORTS],
  output logic anc_fire [NUM_PORTS],
  output logic func_state [NUM_PORTS],
  output logic in_level [NUM_PORTS]
);
  import gpi_tally_pkg::*;

  localparam int FCNT_W = $clog2(FILTER_CYCLES + 1);
  localparam logic [FCNT_W-1:0] FILTER_LAST = FCNT_W'(FILTER_CYCLES - 1);
  localparam logic [FCNT_W-1:0] FCNT_ZERO = '0;

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction : edge_hit

  // Sense seen by the function: polarity 0 inverts raw level
  function automatic logic sense(input logic lvl, input logic pol);
    sense = pol ? lvl : !lvl;
  endfunction : sense

  // Width capped at the tally limit, zero treated as one frame
  function automatic logic [PW_W-1:0] pulse_limit(
      input logic [PW_W-1:0] w);
    if (w == '0) begin
      pulse_limit = PULSE_MIN_FRAMES;
    end else if (w > TALLY_MAX_FRAMES) begin
      pulse_limit = TALLY_MAX_FRAMES;
    end else begin
      pulse_limit = w;
    end
  endfunction : pulse_limit

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  logic sync1_reg [NUM_PORTS];
  logic sync1_next [NUM_PORTS];
  logic sync2_reg [NUM_PORTS];
  logic sync2_next [NUM_PORTS];
  logic filt_reg [NUM_PORTS];
  logic filt_next [NUM_PORTS];
  logic [FCNT_W-1:0] fcnt_reg [NUM_PORTS];
  logic [FCNT_W-1:0] fcnt_next [NUM_PORTS];
  logic samp_reg [NUM_PORTS];
  logic samp_next [NUM_PORTS];
  logic lvl_prev_reg [NUM_PORTS];
  logic lvl_prev_next [NUM_PORTS];
  logic fire_next [NUM_PORTS];
  logic anc_fire_next [NUM_PORTS];
  logic state_next [NUM_PORTS];
  logic in_level_next [NUM_PORTS];
  logic act_prev_reg [NUM_PORTS];
  logic act_prev_next [NUM_PORTS];
  tpulse_t tp_reg [NUM_PORTS];
  tpulse_t tp_next [NUM_PORTS];
  logic [PW_W-1:0] pcnt_reg [NUM_PORTS];
  logic [PW_W-1:0] pcnt_next [NUM_PORTS];
  logic pin_out_next [NUM_PORTS];
  logic pin_oe_next [NUM_PORTS];
  logic src_w [NUM_PORTS];
  logic act_w [NUM_PORTS];
  logic armed_reg;
  logic armed_next;

  // ---------------------------------------------
  // Pin sync and glitch filter
  // ---------------------------------------------
  always_comb begin
    armed_next = 1'b1;
    for (int i = 0; i < NUM_PORTS; i++) begin
      sync1_next[i] = pin_in[i];
      sync2_next[i] = sync1_reg[i];
      filt_next[i] = filt_reg[i];
      fcnt_next[i] = FCNT_ZERO;
      // A level must stand a full 1 ms before it is believed
      if (sync2_reg[i] != filt_reg[i]) begin
        if (fcnt_reg[i] == FILTER_LAST) begin
          filt_next[i] = sync2_reg[i];
        end else begin
          fcnt_next[i] = FCNT_W'(fcnt_reg[i] + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        sync1_reg[i] <= PIN_IDLE_LEVEL;
        sync2_reg[i] <= PIN_IDLE_LEVEL;
        filt_reg[i] <= PIN_IDLE_LEVEL;
        fcnt_reg[i] <= FCNT_ZERO;
      end
    end else begin
      armed_reg <= armed_next;
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      filt_reg <= filt_next;
      fcnt_reg <= fcnt_next;
    end
  end

  // ---------------------------------------------
  // Input trigger
  // ---------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      logic inp;
      logic lvl;
      logic hit;
      inp = 1'b0;
      lvl = 1'b0;
      hit = 1'b0;
      // Manual override replaces the pin as source
      src_w[i] = ovr_en[i] ? ovr_level[i] : filt_reg[i];
      inp = (func_sel[i] == FUNC_INPUT) ||
            (func_sel[i] == FUNC_ANC);
      lvl = sense(src_w[i], polarity[i]);
      samp_next[i] = frame_strobe ? src_w[i] : samp_reg[i];
      lvl_prev_next[i] = lvl;
      state_next[i] = func_state[i];
      in_level_next[i] = src_w[i];
      if (!inp) begin
        state_next[i] = 1'b0;
      end else if (trig_level[i]) begin
        // Both transitions count; level picks the state
        if (lvl != lvl_prev_reg[i]) begin
          hit = 1'b1;
          state_next[i] = lvl;
        end
      end else begin
        // Only frame strobe looks, so one fire per frame
        hit = frame_strobe &&
              edge_hit(samp_reg[i], src_w[i], polarity[i]);
        if (hit) begin
          state_next[i] = !func_state[i];
        end
      end
      if (inp && remote_trig[i]) begin
        hit = 1'b1;
        if (!trig_level[i]) begin
          state_next[i] = !func_state[i];
        end
      end
      // Serial command wins; holds until next input change
      if (inp && cmd_valid[i]) begin
        hit = cmd_level[i] != func_state[i];
        state_next[i] = cmd_level[i];
      end
      fire_next[i] = hit && (func_sel[i] == FUNC_INPUT);
      anc_fire_next[i] = hit && (func_sel[i] == FUNC_ANC);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        samp_reg[i] <= PIN_IDLE_LEVEL;
        lvl_prev_reg[i] <= 1'b0;
        fire[i] <= 1'b0;
        anc_fire[i] <= 1'b0;
        func_state[i] <= 1'b0;
        in_level[i] <= PIN_IDLE_LEVEL;
      end
    end else begin
      samp_reg <= samp_next;
      lvl_prev_reg <= lvl_prev_next;
      fire <= fire_next;
      anc_fire <= anc_fire_next;
      func_state <= state_next;
      in_level <= in_level_next;
    end
  end

  // ---------------------------------------------
  // Tally output
  // ---------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      logic outm;
      logic drive;
      outm = func_sel[i] == FUNC_OUTPUT;
      drive = 1'b0;
      act_w[i] = ovr_en[i] ? ovr_level[i]
                           : |(on_air & tally_sel[i]);
      act_prev_next[i] = act_w[i];
      tp_next[i] = tp_reg[i];
      pcnt_next[i] = pcnt_reg[i];
      if (!outm || trig_level[i]) begin
        tp_next[i] = TP_IDLE;
        pcnt_next[i] = '0;
        drive = act_w[i];
      end else begin
        unique case (tp_reg[i])
          TP_IDLE: begin
            if (act_w[i] && !act_prev_reg[i]) begin
              tp_next[i] = TP_PULSE;
              pcnt_next[i] = '0;
            end
          end
          TP_PULSE: begin
            drive = 1'b1;
            // Event end or frame count, whichever first
            if (!act_w[i]) begin
              tp_next[i] = TP_IDLE;
            end else if (frame_strobe) begin
              pcnt_next[i] = PW_W'(pcnt_reg[i] + 1'b1);
              if (pcnt_reg[i] + 1'b1 >=
                  pulse_limit(pulse_frames[i])) begin
                tp_next[i] = TP_HOLD;
              end
            end
          end
          TP_HOLD: begin
            if (!act_w[i]) begin
              tp_next[i] = TP_IDLE;
            end
          end
          default: begin
            tp_next[i] = TP_IDLE;
          end
        endcase
      end
      // Polarity 0 is active low: idle high, low while active
      pin_out_next[i] = outm ? (drive ? polarity[i] : !polarity[i])
                             : PIN_IDLE_LEVEL;
      pin_oe_next[i] = outm;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        act_prev_reg[i] <= 1'b0;
        tp_reg[i] <= TP_IDLE;
        pcnt_reg[i] <= '0;
        pin_out[i] <= PIN_IDLE_LEVEL;
        pin_oe[i] <= 1'b0;
      end
    end else begin
      act_prev_reg <= act_prev_next;
      tp_reg <= tp_next;
      pcnt_reg <= pcnt_next;
      pin_out <= pin_out_next;
      pin_oe <= pin_oe_next;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  // Release edge still shows reset values, so checks wait one edge
  default disable iff (rst || !armed_reg);

  // Ports are checked one by one; config never crosses ports
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
    sequence s_tally_rise;
      func_sel[g] == FUNC_OUTPUT && !trig_level[g] &&
      tp_reg[g] == TP_IDLE && act_w[g] && !act_prev_reg[g];
    endsequence
    sequence s_pulse_on;
      tp_reg[g] == TP_PULSE ##1 pin_out[g] == polarity[g];
    endsequence
    sequence s_edge_seen;
      frame_strobe && func_sel[g] == FUNC_INPUT && !trig_level[g] &&
      !remote_trig[g] && !cmd_valid[g] &&
      edge_hit(samp_reg[g], src_w[g], polarity[g]);
    endsequence

    a_sync_chain: assert property (
      ##2 sync2_reg[g] == $past(pin_in[g], 2))
      else $error("pin sync chain broken");
    a_filter_hold: assert property (
      $changed(filt_reg[g]) |-> $past(fcnt_reg[g]) == FILTER_LAST)
      else $error("filter accepted a short pulse");
    a_edge_fires: assert property (
      s_edge_seen |=> fire[g] && func_state[g] != $past(func_state[g]))
      else $error("edge did not fire");
    a_edge_frame: assert property (
      (!frame_strobe && !trig_level[g] && !remote_trig[g] &&
       !cmd_valid[g]) |=> !fire[g])
      else $error("edge fired off frame");
    a_level_state: assert property (
      (func_sel[g] == FUNC_INPUT && trig_level[g] && !cmd_valid[g] &&
       sense(src_w[g], polarity[g]) != lvl_prev_reg[g])
      |=> fire[g] && func_state[g] == sense($past(src_w[g]),
                                            $past(polarity[g])))
      else $error("level state wrong");
    a_none_quiet: assert property (
      func_sel[g] == FUNC_NONE |=> !fire[g] && !anc_fire[g] &&
                                   !pin_oe[g] && !func_state[g])
      else $error("unused port active");
    a_remote_fire: assert property (
      (func_sel[g] == FUNC_INPUT && remote_trig[g] && !cmd_valid[g])
      |=> fire[g])
      else $error("remote trigger lost");
    a_tally_level: assert property (
      (func_sel[g] == FUNC_OUTPUT && trig_level[g])
      |=> pin_oe[g] && pin_out[g] ==
          ($past(act_w[g]) ? $past(polarity[g]) : !$past(polarity[g])))
      else $error("tally level wrong");
    a_tally_start: assert property (
      s_tally_rise |=> s_pulse_on)
      else $error("tally pulse did not start");
    a_pulse_cap: assert property (
      tp_reg[g] == TP_PULSE |-> pcnt_reg[g] < TALLY_MAX_FRAMES)
      else $error("tally pulse overran");
    a_cmd_wins: assert property (
      (func_sel[g] inside {FUNC_INPUT, FUNC_ANC}) && cmd_valid[g]
      |=> func_state[g] == $past(cmd_level[g]))
      else $error("serial command did not win");
    a_ovr_source: assert property (
      ovr_en[g] |=> in_level[g] == $past(ovr_level[g]))
      else $error("override level not used");
    a_out_idle: assert property (
      func_sel[g] != FUNC_OUTPUT |=> pin_out[g] == PIN_IDLE_LEVEL &&
                                     !pin_oe[g])
      else $error("idle pin not released high");
  end

endmodule : gpi_tally_port_logic

// File: src/gpi_tally_pkg.sv
// How it works
// - Port works as input, output or ANC.
// - Port count is a build parameter.
// - Input pulses under 1 ms are dropped.
// - Falling or rising edge fires function.
// - Edges sampled once per frame, fire once.
// - Level mode acts on both transitions.
// - Active low/high level applies function.
// - Polarity inverts sense for both types.
// - Other command sources override trigger action.
// - Remote trigger fires the port's function.
// - Function none makes the port inert.
// - Every port has its own configuration.
// - Per-port pulse width counted in frames.
// - Manual override forces the port level.
// - Tally asserts when selected input on air.
// - Tally active high or active low.
// - Edge tally pulse ends by 30 frames.
// - Tally at polarity 0 idles high, drives low active.
package gpi_tally_pkg;

  // ---------------------------------------------
  // Port modes and tally pulse states
  // ---------------------------------------------
  typedef enum logic [1:0] {
    FUNC_NONE = 2'h0,
    FUNC_INPUT = 2'h1,
    FUNC_OUTPUT = 2'h2,
    FUNC_ANC = 2'h3
  } func_t;

  typedef enum logic [1:0] {
    TP_IDLE = 2'h0,
    TP_PULSE = 2'h1,
    TP_HOLD = 2'h3
  } tpulse_t;

  // ---------------------------------------------
  // Sizes and timing
  // ---------------------------------------------
  localparam int NUM_PORTS_DEF = 8;
  localparam int ON_AIR_INPUTS = 6;
  localparam int PW_W = 8;
  localparam logic [PW_W-1:0] TALLY_MAX_FRAMES = 8'h1E;
  localparam logic [PW_W-1:0] PULSE_MIN_FRAMES = 8'h01;
  localparam int CLK_FREQ_MHZ = 100;
  localparam int FILTER_TIME_US = 1000;
  localparam int FILTER_CYCLES_DEF = FILTER_TIME_US * CLK_FREQ_MHZ;
  localparam logic PIN_IDLE_LEVEL = 1'h1;

endpackage : gpi_tally_pkg

// File: sim/gpi_far_side.sv
`timescale 1ns/1ns
module gpi_far_side #(
  parameter int N = 8
) (
  input wire logic clk_sys,
  input wire logic pin_out [N],
  input wire logic pin_oe [N],
  output logic pin_in [N]
);
  // -------------------------------------------
  // Contacts to ground, pull-up when open
  // -------------------------------------------
  logic closed [N];

  initial begin
    for (int i = 0; i < N; i++) begin
      closed[i] = 1'b0;
    end
  end

  // Driven ports show their own level, never the contact
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : !closed[i];
    end
  end

  task automatic contact(input int p, input logic c);
    @(posedge clk_sys);
    closed[p] <= c;
  endtask : contact

  task automatic press(input int p, input int n);
    contact(p, 1'b1);
    repeat (n - 1) @(posedge clk_sys);
    contact(p, 1'b0);
  endtask : press
endmodule : gpi_far_side

// File: sim/gpi_tally_port_logic_tb_top.sv
`timescale 1ns/1ns
module gpi_tally_port_logic_tb_top;
  import gpi_tally_pkg::*;
  localparam int N = 8;
  localparam int FC = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic frame_strobe = 1'b0;
  logic pin_in [N];
  func_t func_sel [N];
  logic trig_level [N];
  logic polarity [N];
  logic [PW_W-1:0] pulse_frames [N];
  logic ovr_en [N];
  logic ovr_level [N];
  logic remote_trig [N];
  logic cmd_valid [N];
  logic cmd_level [N];
  logic [ON_AIR_INPUTS-1:0] on_air = 6'h00;
  logic [ON_AIR_INPUTS-1:0] tally_sel [N];
  logic pin_out [N];
  logic pin_oe [N];
  logic fire [N];
  logic anc_fire [N];
  logic func_state [N];
  logic in_level [N];
  int failures = 0;
  int cmp_count = 0;
  int fires [N] = '{default: 0};
  int ancs [N] = '{default: 0};

  always #5 clk_sys = !clk_sys;

  gpi_tally_port_logic #(.NUM_PORTS(N), .FILTER_CYCLES(FC))
    u_gpi_tally_port_logic (.clk_sys(clk_sys), .rst(rst),
    .frame_strobe(frame_strobe), .pin_in(pin_in), .func_sel(func_sel),
    .trig_level(trig_level), .polarity(polarity),
    .pulse_frames(pulse_frames), .ovr_en(ovr_en), .ovr_level(ovr_level),
    .remote_trig(remote_trig), .cmd_valid(cmd_valid),
    .cmd_level(cmd_level), .on_air(on_air), .tally_sel(tally_sel),
    .pin_out(pin_out), .pin_oe(pin_oe), .fire(fire),
    .anc_fire(anc_fire), .func_state(func_state), .in_level(in_level));

  gpi_far_side #(.N(N)) u_gpi_far_side (.clk_sys(clk_sys),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  // -------------------------------------------
  // Pulse tallies, so no one-cycle fire is missed
  // -------------------------------------------
  always @(posedge clk_sys) begin
    for (int i = 0; i < N; i++) begin
      if (fire[i] === 1'b1) fires[i]++;
      if (anc_fire[i] === 1'b1) ancs[i]++;
    end
  end

  // -------------------------------------------
  // Tasks
  // -------------------------------------------
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic frame();
    @(posedge clk_sys);
    frame_strobe <= 1'b1;
    @(posedge clk_sys);
    frame_strobe <= 1'b0;
    cyc(3);
  endtask : frame

  // Bounded wait for the filtered level, then compare it
  task automatic wait_lvl(input int p, input logic v);
    int k;
    k = 0;
    while (in_level[p] !== v && k < 4 * FC) begin
      cyc(1);
      k++;
    end
    chk(in_level[p], v);
  endtask : wait_lvl

  // -------------------------------------------
  // Tests
  // -------------------------------------------
  initial begin
    for (int i = 0; i < N; i++) begin
      func_sel[i] = FUNC_INPUT;
      trig_level[i] = 1'b0;
      polarity[i] = 1'b0;
      pulse_frames[i] = 8'h02;
      ovr_en[i] = 1'b0;
      ovr_level[i] = 1'b0;
      remote_trig[i] = 1'b0;
      cmd_valid[i] = 1'b0;
      cmd_level[i] = 1'b0;
      tally_sel[i] = 6'h00;
    end
    polarity[1] = 1'b1;
    trig_level[2] = 1'b1;
    polarity[2] = 1'b1;
    func_sel[3] = FUNC_NONE;
    func_sel[4] = FUNC_ANC;
    func_sel[5] = FUNC_OUTPUT;
    trig_level[5] = 1'b1;
    tally_sel[5] = 6'h04;
    func_sel[6] = FUNC_OUTPUT;
    polarity[6] = 1'b1;
    tally_sel[6] = 6'h08;
    cyc(5);
    for (int i = 0; i < N; i++) begin
      chk({pin_out[i], pin_oe[i], func_state[i], in_level[i]}, 8'h09);
    end
    @(posedge clk_sys);
    rst <= 1'b0;
    $display("reset done");
    u_gpi_far_side.press(0, FC / 2);
    cyc(3 * FC);
    chk(in_level[0], 1'b1);
    frame();
    chk(fires[0][7:0], 8'h00);
    $display("glitch done");
    for (int p = 0; p < 5; p++) begin
      u_gpi_far_side.contact(p, 1'b1);
    end
    wait_lvl(4, 1'b0);
    cyc(2);
    chk(func_state[2], 1'b0);
    chk(fires[0][7:0], 8'h00);
    frame();
    chk(fires[0][7:0], 8'h01);
    chk(func_state[0], 1'b1);
    chk(fires[1][7:0], 8'h00);
    chk(ancs[4][7:0], 8'h01);
    chk(fires[4][7:0], 8'h00);
    chk(fires[3][7:0], 8'h00);
    chk(ancs[3][7:0], 8'h00);
    chk(pin_oe[3], 1'b0);
    frame();
    chk(fires[0][7:0], 8'h01);
    for (int p = 0; p < 5; p++) begin
      u_gpi_far_side.contact(p, 1'b0);
    end
    wait_lvl(4, 1'b1);
    cyc(2);
    chk(func_state[2], 1'b1);
    frame();
    chk(fires[1][7:0], 8'h01);
    chk(fires[0][7:0], 8'h01);
    $display("edges done");
    @(posedge clk_sys);
    ovr_en[7] <= 1'b1;
    cyc(2);
    chk(in_level[7], 1'b0);
    frame();
    chk(fires[7][7:0], 8'h01);
    @(posedge clk_sys);
    remote_trig[7] <= 1'b1;
    @(posedge clk_sys);
    remote_trig[7] <= 1'b0;
    cyc(2);
    chk(fires[7][7:0], 8'h02);
    chk(func_state[7], 1'b0);
    @(posedge clk_sys);
    cmd_valid[7] <= 1'b1;
    cmd_level[7] <= 1'b1;
    @(posedge clk_sys);
    cmd_valid[7] <= 1'b0;
    cyc(2);
    chk(func_state[7], 1'b1);
    $display("override done");
    @(posedge clk_sys);
    on_air <= 6'h04;
    cyc(2);
    chk({pin_oe[5], pin_out[5]}, 8'h02);
    @(posedge clk_sys);
    on_air <= 6'h08;
    cyc(2);
    chk(pin_out[5], 1'b1);
    chk(pin_out[6], 1'b1);
    frame();
    chk(pin_out[6], 1'b1);
    frame();
    chk(pin_out[6], 1'b0);
    @(posedge clk_sys);
    on_air <= 6'h00;
    cyc(2);
    @(posedge clk_sys);
    on_air <= 6'h08;
    cyc(3);
    chk(pin_out[6], 1'b1);
    @(posedge clk_sys);
    on_air <= 6'h00;
    cyc(2);
    chk(pin_out[6], 1'b0);
    $display("tally done");
    end_of_test();
  end

  // Whole run is under 150 cycles; this is far beyond it
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule : gpi_tally_port_logic_tb_top
